// file: i2cms_assertions.sv
/* Port-level checks for the serial controller.
   Bound to i2cms_core; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none

module i2cms_assertions (
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire i2cms_pkg::i2cms_sfr_req_t sfr_req,
  input wire logic [7:0]                sfr_rdata,
  input wire logic                      irq,
  input wire logic                      scl_in,
  input wire logic                      scl_out,
  input wire logic                      scl_oe_n,
  input wire logic                      sda_in,
  input wire logic                      sda_out,
  input wire logic                      sda_oe_n
);
  localparam logic [9:0] HALF [8] = '{10'h008, 10'h00C, 10'h00F, 10'h01E,
                                      10'h03C, 10'h078, 10'h0F0, 10'h1E0};
  logic [2:0] rate;
  logic       en;
  logic [9:0] hi_cnt;
  logic       armed;
  logic       scl_q;
  logic       sda_q;
  logic       oe_q;
  wire        rd_st  = sfr_req.rd && sfr_req.addr == 8'hD9;
  wire        wr_ctl = sfr_req.wr && sfr_req.addr == 8'hD8;
  wire        wr_rel = wr_ctl || (sfr_req.wr && sfr_req.addr == 8'hDA);
  wire        mapped = sfr_req.addr inside {8'hD2, [8'hD8:8'hDB]};
  wire        cond   = scl_in && scl_q && sda_in != sda_q;

  // Only high phases of our own clock are timed; conditions and stretching disarm
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate   <= 3'h0;
      en     <= 1'b0;
      hi_cnt <= 10'h000;
      armed  <= 1'b0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      oe_q   <= 1'b1;
    end else begin
      if (wr_ctl) rate <= {sfr_req.wdata[7], sfr_req.wdata[1:0]};
      if (wr_ctl) en <= sfr_req.wdata[6];
      hi_cnt <= scl_oe_n ? hi_cnt + 10'h001 : 10'h000;
      scl_q  <= scl_in;
      sda_q  <= sda_in;
      oe_q   <= scl_oe_n;
      if (cond || (!scl_in && scl_oe_n)) armed <= 1'b0;
      else if (scl_oe_n && !oe_q) armed <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_status_irq: assert property (rd_st |=> sfr_rdata[5] == $past(irq))
    else $error("status irq bit differs from irq");
  chk_irq_read_clear: assert property (rd_st && irq && !scl_oe_n |=> !irq)
    else $error("irq not cleared by status read");
  chk_off_release: assert property (!en |-> scl_oe_n && sda_oe_n)
    else $error("line pulled while disabled");
  chk_rdata_stands: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (sfr_req.rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_scl_half: assert property ($fell(scl_oe_n) && armed |-> hi_cnt == HALF[rate])
    else $error("clock high phase wrong length");
  chk_irq_hold: assert property ($rose(irq) && !scl_in |-> ##[0:1] !scl_oe_n)
    else $error("clock not held at byte interrupt");
  chk_hold_keep: assert property (!scl_oe_n && irq && !wr_rel |=> !scl_oe_n)
    else $error("hold released without a write");
endmodule

bind i2cms_core i2cms_assertions i2cms_assertions_i (
  .clk(clk), .resetn(resetn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .irq(irq),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n));
`default_nettype wire

// file: i2cms_bus_peer.sv
/* Other party on the two-wire bus: acking slave and task-driven master.
   Assumes wired-AND lines with pull-ups formed by the bench. */
`timescale 1ns/10ps
`default_nettype none

module i2cms_bus_peer (
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] hp,
  input  wire logic       ack_on,
  output var  logic       scl_n,
  output var  logic       sda_n,
  output var  logic [7:0] rx
);
  logic       mst  = 1'b0;
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh   = 8'h00;
  initial begin
    scl_n = 1'b1;
    sda_n = 1'b1;
    rx    = 8'h00;
  end
  always @(negedge sda) if (scl) bitn = 4'h0;
  // Slave side: MSB first, ack only when told, released lines float high
  always @(posedge scl) if (!mst) begin
    if (bitn == 4'h8) bitn = 4'h0;
    else begin
      sh   = {sh[6:0], sda};
      bitn = bitn + 4'h1;
      if (bitn == 4'h8) rx = sh;
    end
  end
  always @(negedge scl) if (!mst) sda_n <= !(bitn == 4'h8 && ack_on);
  task automatic hb();
    repeat (hp) @(posedge clk);
  endtask
  // Waits out a held clock, bounded
  task automatic up();
    int k;
    scl_n <= 1'b1;
    for (k = 0; k < 40000 && scl !== 1'b1; k++) @(posedge clk);
  endtask
  task automatic m_start();
    mst = 1'b1;
    sda_n <= 1'b0;
    hb();
    scl_n <= 1'b0;
    hb();
  endtask
  task automatic m_bit(input logic b, output logic r);
    sda_n <= b;
    hb();
    up();
    hb();
    r = sda;
    scl_n <= 1'b0;
    hb();
  endtask
  task automatic m_byte(input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) m_bit(b[i], r);
    m_bit(1'b1, a);
  endtask
  task automatic m_stop();
    sda_n <= 1'b0;
    hb();
    up();
    hb();
    sda_n <= 1'b1;
    hb();
    mst = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: i2cms_clkdiv.sv
/*
 * Half-period tick generator for the master serial clock.
 * Assumes run drops whenever the sequencer must not advance.
 */
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_defs.svh"

module i2cms_clkdiv (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [2:0] rate_sel,
  output logic            tick
);

  logic [8:0] cnt;
  wire  [8:0] half;

  // Half of the oscillator divisor per rate code
  assign half = (rate_sel == 3'h0) ? `I2CMS_HALF_DIV0 :
                (rate_sel == 3'h1) ? `I2CMS_HALF_DIV1 :
                (rate_sel == 3'h2) ? `I2CMS_HALF_DIV2 :
                (rate_sel == 3'h3) ? `I2CMS_HALF_DIV3 :
                (rate_sel == 3'h4) ? `I2CMS_HALF_DIV4 :
                (rate_sel == 3'h5) ? `I2CMS_HALF_DIV5 :
                (rate_sel == 3'h6) ? `I2CMS_HALF_DIV6 : `I2CMS_HALF_DIV7;

  assign tick = run & (cnt == half - 9'h001);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 9'h000;
    end else if (!run || tick) begin
      cnt <= 9'h000;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end

endmodule
`default_nettype wire

// file: i2cms_cond_detect.sv
/*
 * START and STOP recognition with a programmable hold filter.
 * Assumes the bus lines are already synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_defs.svh"

module i2cms_cond_detect (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] setup,
  output logic            start_det,
  output logic            stop_det
);

  logic       samp;
  logic       sda_q;
  logic       arm;
  logic       kind;
  logic [7:0] cnt;

  // Sample strobe at half the clock rate
  wire       edge_s   = samp & scl & sda_q & ~sda;
  wire       edge_p   = samp & scl & ~sda_q & sda;
  wire       edge_any = edge_s | edge_p;
  wire       kind_now = edge_any ? edge_p : kind;
  wire       hold_ok  = samp & arm & scl & (sda == kind);
  wire [7:0] need     = setup[`I2CMS_SETUP_EN] ? ({1'b0, setup[6:0]} + 8'h01) : 8'h01;
  wire [7:0] next_cnt = edge_any ? 8'h01 : cnt + 8'h01;
  wire       hit      = (edge_any | hold_ok) & (next_cnt == need);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp      <= 1'b0;
      sda_q     <= 1'b1;
      arm       <= 1'b0;
      kind      <= 1'b0;
      cnt       <= 8'h00;
      start_det <= 1'b0;
      stop_det  <= 1'b0;
    end else begin
      samp      <= ~samp;
      start_det <= hit & ~kind_now;
      stop_det  <= hit & kind_now;
      if (samp) begin
        sda_q <= sda;
        arm   <= (edge_any | hold_ok) & ~hit;
        kind  <= kind_now;
        cnt   <= next_cnt;
      end
    end
  end

endmodule
`default_nettype wire

// file: i2cms_core.sv
/*
 * Two-wire serial controller: master and slave, transmitter and receiver,
 * reached through special function registers on the CPU side.
 * Assumes open-drain pads outside, bus inputs synchronous to clk.
 */
// Functional notes
// - Master clock divisor from three rate bits
// - Status register ignores all writes
// - Status value distinguishes each bus situation
// - Own address with ack enable raises irq
// - General call raises irq when enabled and ack enable is set
// - Master irq after every byte, even a lost data byte
// - Addressed slave irq after every data byte
// - Stop while addressed raises stop irq
// - Shift register moves MSB first
// - Status bit order gc down to slave
// - Stop flag set on bus STOP
// - Busy flag while another master holds bus
// - Lost flag on master arbitration loss
// - Nack flag follows receiver acknowledge bit
// - Transmitter and slave flags track role
// - Reading status clears interrupt flag
// - Slave answers only own address or enabled general call
// - Hold filter register resets to zero
// - Hold sample count is field plus one
// - Disabled controller releases both lines
// - Ack driven low only when enabled
// - Start request issues START, STOP clears stop
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_defs.svh"

module i2cms_core (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire i2cms_pkg::i2cms_sfr_req_t sfr_req,
  output logic [7:0]                    sfr_rdata,
  output logic                          irq,
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe_n,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n
);

  logic [7:0]            serial_control;
  logic [7:0]            own_slave_address;
  logic [7:0]            hold_time_detect_setup;
  logic [7:0]            serial_data_shift;
  i2cms_pkg::i2cms_status_t st;
  i2cms_pkg::i2cms_mst_t mst;
  i2cms_pkg::i2cms_mst_t next_mst;
  logic [1:0]            phase;
  logic [1:0]            next_phase;
  logic                  mst_sda_low;
  logic                  next_mst_sda_low;
  logic                  mst_scl_low;
  logic                  next_mst_scl_low;
  logic                  scl_q;
  logic                  in_frame;
  logic                  engaged;
  logic                  addr_phase;
  logic                  addressed;
  logic                  hold;
  logic                  out_bit;
  logic [3:0]            bit_cnt;
  logic                  tick;
  logic                  start_det;
  logic                  stop_det;

  // Register access decode
  wire wr_ctrl  = sfr_req.wr & (sfr_req.addr == `I2CMS_ADR_CTRL);
  wire wr_data  = sfr_req.wr & (sfr_req.addr == `I2CMS_ADR_DATA);
  wire wr_own   = sfr_req.wr & (sfr_req.addr == `I2CMS_ADR_OWN);
  wire wr_setup = sfr_req.wr & (sfr_req.addr == `I2CMS_ADR_SETUP);
  wire rd_stat  = sfr_req.rd & (sfr_req.addr == `I2CMS_ADR_STATUS);

  wire       iface_enable = serial_control[`I2CMS_CTL_EN];
  wire       ack_enable   = serial_control[`I2CMS_CTL_ACK];
  wire       start_request = serial_control[`I2CMS_CTL_START];
  wire       stop_request = serial_control[`I2CMS_CTL_STOP];
  wire [2:0] rate_sel     = {serial_control[`I2CMS_CTL_CR_HI],
                             serial_control[`I2CMS_CTL_CR_MID],
                             serial_control[`I2CMS_CTL_CR_LO]};

  // Bus edges and byte progress
  wire scl_rise   = iface_enable & scl_in & ~scl_q;
  wire scl_fall   = iface_enable & ~scl_in & scl_q;
  wire active     = in_frame & engaged;
  wire data_bit   = bit_cnt < 4'h8;
  wire ack_bit    = bit_cnt == 4'h8;
  wire master     = (mst != i2cms_pkg::I2CMS_M_IDLE);
  wire lost_now   = active & scl_rise & data_bit & (mst == i2cms_pkg::I2CMS_M_RUN) &
                    st.tx_flag & out_bit & ~sda_in;
  wire byte_done  = active & scl_fall & ack_bit;

  // Address recognition on the eighth falling edge
  wire own_match  = serial_data_shift[7:1] == own_slave_address[7:1];
  wire gc_match   = (serial_data_shift[7:1] == `I2CMS_GC_ADDR) &
                    own_slave_address[`I2CMS_OWN_GC_EN];
  wire addr_done  = active & scl_fall & (bit_cnt == 4'h7) & addr_phase & ~master;
  wire slave_hit  = addr_done & (own_match | gc_match);

  // Interrupt causes; a stop while addressed is the stop class
  wire ack_int    = byte_done & ((addr_phase & addressed & ack_enable) |
                                 (master | (~addr_phase & st.arbitration_lost_flag)) |
                                 (~addr_phase & addressed));
  wire stop_int   = stop_det & addressed;
  wire irq_set    = ack_int | stop_int;
  wire release_hold = hold & (wr_data | (wr_ctrl & ~(master & |sfr_req.wdata[5:4])));

  // Acknowledge drive and data drive
  wire ack_cond   = addr_phase ? (addressed & ack_enable & ~master)
                               : (~st.tx_flag & ack_enable);
  wire eng_sda_low = active & ((data_bit & st.tx_flag & ~out_bit) | (ack_bit & ack_cond));
  wire seq_owns   = (mst == i2cms_pkg::I2CMS_M_START) | (mst == i2cms_pkg::I2CMS_M_RSTART) |
                    (mst == i2cms_pkg::I2CMS_M_STOP);
  wire sda_low    = iface_enable & (seq_owns ? mst_sda_low : eng_sda_low);
  wire scl_low    = iface_enable & (hold | (master & mst_scl_low));

  // Released clock held low elsewhere stalls the divider
  wire stretch    = master & ~mst_scl_low & ~scl_in;
  wire div_run    = master & ~hold & ~stretch;

  // Open-drain pads: drive low only, release when disabled
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = ~scl_low;
  assign sda_oe_n = ~sda_low;
  assign irq      = st.irq_flag;

  // Status read view and unmapped reads answer zero
  wire [7:0] rd_mux = (sfr_req.addr == `I2CMS_ADR_STATUS) ? st :
                      (sfr_req.addr == `I2CMS_ADR_CTRL)   ? serial_control :
                      (sfr_req.addr == `I2CMS_ADR_DATA)   ? serial_data_shift :
                      (sfr_req.addr == `I2CMS_ADR_OWN)    ? own_slave_address :
                      (sfr_req.addr == `I2CMS_ADR_SETUP)  ? hold_time_detect_setup : 8'h00;

  i2cms_clkdiv u_div (
    .clk      (clk),
    .resetn   (resetn),
    .run      (div_run),
    .rate_sel (rate_sel),
    .tick     (tick)
  );

  i2cms_cond_detect u_det (
    .clk       (clk),
    .resetn    (resetn),
    .scl       (scl_in),
    .sda       (sda_in),
    .setup     (hold_time_detect_setup),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // Master sequencer
  always_comb begin
    next_mst         = mst;
    next_phase       = phase;
    next_mst_sda_low = mst_sda_low;
    next_mst_scl_low = mst_scl_low;
    case (mst)
      i2cms_pkg::I2CMS_M_IDLE: begin
        next_mst_sda_low = 1'b0;
        next_mst_scl_low = 1'b0;
        // START only on a free bus
        if (start_request && !in_frame && scl_in && sda_in) begin
          next_mst         = i2cms_pkg::I2CMS_M_START;
          next_mst_sda_low = 1'b1;
        end
      end
      i2cms_pkg::I2CMS_M_START: begin
        if (tick) begin
          next_mst         = i2cms_pkg::I2CMS_M_RUN;
          next_mst_scl_low = 1'b1;
        end
      end
      i2cms_pkg::I2CMS_M_RUN: begin
        if (lost_now) begin
          next_mst = i2cms_pkg::I2CMS_M_IDLE;
        end else if (hold && start_request) begin
          next_mst         = i2cms_pkg::I2CMS_M_RSTART;
          next_phase       = 2'h0;
          next_mst_sda_low = 1'b0;
          next_mst_scl_low = 1'b1;
        end else if (hold && stop_request) begin
          next_mst         = i2cms_pkg::I2CMS_M_STOP;
          next_phase       = 2'h0;
          next_mst_sda_low = 1'b1;
          next_mst_scl_low = 1'b1;
        end else if (tick) begin
          next_mst_scl_low = ~mst_scl_low;
        end
      end
      i2cms_pkg::I2CMS_M_RSTART: begin
        if (tick && phase == 2'h0) begin
          next_phase       = 2'h1;
          next_mst_scl_low = 1'b0;
        end else if (tick) begin
          next_mst         = i2cms_pkg::I2CMS_M_START;
          next_mst_sda_low = 1'b1;
        end
      end
      i2cms_pkg::I2CMS_M_STOP: begin
        if (tick && phase == 2'h0) begin
          next_phase       = 2'h1;
          next_mst_scl_low = 1'b0;
        end else if (tick && phase == 2'h1) begin
          next_phase       = 2'h2;
          next_mst_sda_low = 1'b0;
        end else if (phase == 2'h2 && stop_det) begin
          next_mst = i2cms_pkg::I2CMS_M_IDLE;
        end
      end
      default: begin
        next_mst = i2cms_pkg::I2CMS_M_IDLE;
      end
    endcase
    if (!iface_enable) begin
      next_mst = i2cms_pkg::I2CMS_M_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mst         <= i2cms_pkg::I2CMS_M_IDLE;
      phase       <= 2'h0;
      mst_sda_low <= 1'b0;
      mst_scl_low <= 1'b0;
      scl_q       <= 1'b1;
      sfr_rdata   <= 8'h00;
    end else begin
      mst         <= next_mst;
      phase       <= next_phase;
      mst_sda_low <= next_mst_sda_low;
      mst_scl_low <= next_mst_scl_low;
      scl_q       <= scl_in;
      if (sfr_req.rd) begin
        sfr_rdata <= rd_mux;
      end
    end
  end

  // Software registers; hardware set or clear of control bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_control         <= `I2CMS_RST_CTRL;
      own_slave_address      <= `I2CMS_RST_OWN;
      hold_time_detect_setup <= `I2CMS_RST_SETUP;
    end else begin
      if (wr_ctrl) begin
        serial_control <= sfr_req.wdata;
      end else begin
        if (stop_det) begin
          serial_control[`I2CMS_CTL_STOP] <= 1'b0;
        end
        if (mst == i2cms_pkg::I2CMS_M_START && tick) begin
          serial_control[`I2CMS_CTL_START] <= 1'b0;
        end
      end
      // Address flag set wins over a software clear
      if (slave_hit) begin
        serial_control[`I2CMS_CTL_ADDR] <= 1'b1;
      end
      if (wr_own) begin
        own_slave_address <= sfr_req.wdata;
      end
      if (wr_setup) begin
        hold_time_detect_setup <= sfr_req.wdata;
      end
    end
  end

  // Shift register and outgoing bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_data_shift <= `I2CMS_RST_DATA;
      out_bit           <= 1'b1;
    end else if (active && scl_rise && data_bit) begin
      serial_data_shift <= {serial_data_shift[6:0], sda_in};
    end else if (wr_data) begin
      serial_data_shift <= sfr_req.wdata;
      out_bit           <= sfr_req.wdata[7];
    end else if (active && scl_fall && bit_cnt < 4'h7) begin
      // Next bit changes only while the clock is low
      out_bit <= serial_data_shift[7];
    end
  end

  // Frame tracking and byte engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_frame   <= 1'b0;
      engaged    <= 1'b0;
      addr_phase <= 1'b0;
      addressed  <= 1'b0;
      hold       <= 1'b0;
      bit_cnt    <= 4'h0;
    end else if (!iface_enable) begin
      in_frame   <= 1'b0;
      engaged    <= 1'b0;
      addressed  <= 1'b0;
      hold       <= 1'b0;
    end else if (stop_det) begin
      in_frame   <= 1'b0;
      engaged    <= 1'b0;
      addressed  <= 1'b0;
      hold       <= 1'b0;
    end else if (start_det) begin
      in_frame   <= 1'b1;
      engaged    <= 1'b1;
      addr_phase <= 1'b1;
      addressed  <= 1'b0;
      hold       <= 1'b0;
      bit_cnt    <= 4'hF;
    end else begin
      if (scl_fall && active) begin
        bit_cnt <= ack_bit ? 4'h0 : bit_cnt + 4'h1;
      end
      if (addr_done) begin
        addressed <= own_match | gc_match;
        engaged   <= own_match | gc_match;
      end
      if (byte_done) begin
        addr_phase <= 1'b0;
        engaged    <= master | addressed;
        // Clock held low until software answers the byte
        hold       <= ack_int;
      end else if (release_hold || (hold && (start_request || stop_request) && master)) begin
        hold <= 1'b0;
      end
    end
  end

  // Status flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      // Read clears, a simultaneous event still sets
      if (irq_set) begin
        st.irq_flag <= 1'b1;
      end else if (rd_stat) begin
        st.irq_flag <= 1'b0;
      end
      if (stop_det) begin
        st.stop_flag <= 1'b1;
      end else if (rd_stat) begin
        st.stop_flag <= 1'b0;
      end
      if (start_det) begin
        st.general_call_flag <= 1'b0;
      end else if (addr_done) begin
        st.general_call_flag <= gc_match & ~own_match;
      end
      if (lost_now) begin
        st.arbitration_lost_flag <= 1'b1;
      end else if (mst == i2cms_pkg::I2CMS_M_START) begin
        st.arbitration_lost_flag <= 1'b0;
      end
      if (active && scl_rise && ack_bit && st.tx_flag) begin
        st.nack_seen_flag <= sda_in;
      end
      // Live role flags follow the bus on the next clock
      st.bus_busy_flag <= iface_enable & in_frame & ~master & ~stop_det;
      st.slave_role_flag <= iface_enable & ((addressed & ~stop_det & ~start_det) |
                                            slave_hit);
      if (!iface_enable || stop_det || lost_now) begin
        st.tx_flag <= 1'b0;
      end else if (start_det) begin
        st.tx_flag <= master;
      end else if (master && byte_done && addr_phase) begin
        st.tx_flag <= ~serial_data_shift[0];
      end else if (addr_done) begin
        st.tx_flag <= (own_match | gc_match) & serial_data_shift[0];
      end
    end
  end

endmodule
`default_nettype wire

// file: i2cms_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * two-wire serial controller. Included by every design file of the block except the package.
 */
`ifndef I2CMS_DEFS_SVH
`define I2CMS_DEFS_SVH

`define I2CMS_ADR_SETUP   8'hD2
`define I2CMS_ADR_CTRL    8'hD8
`define I2CMS_ADR_STATUS  8'hD9
`define I2CMS_ADR_DATA    8'hDA
`define I2CMS_ADR_OWN     8'hDB

`define I2CMS_RST_SETUP   8'h00
`define I2CMS_RST_CTRL    8'h00
`define I2CMS_RST_DATA    8'h00
`define I2CMS_RST_OWN     8'h00

`define I2CMS_CTL_CR_HI   7
`define I2CMS_CTL_EN      6
`define I2CMS_CTL_START   5
`define I2CMS_CTL_STOP    4
`define I2CMS_CTL_ADDR    3
`define I2CMS_CTL_ACK     2
`define I2CMS_CTL_CR_MID  1
`define I2CMS_CTL_CR_LO   0

`define I2CMS_OWN_GC_EN   0
`define I2CMS_SETUP_EN    7
`define I2CMS_GC_ADDR     7'h00

`define I2CMS_HALF_DIV0   9'h008
`define I2CMS_HALF_DIV1   9'h00C
`define I2CMS_HALF_DIV2   9'h00F
`define I2CMS_HALF_DIV3   9'h01E
`define I2CMS_HALF_DIV4   9'h03C
`define I2CMS_HALF_DIV5   9'h078
`define I2CMS_HALF_DIV6   9'h0F0
`define I2CMS_HALF_DIV7   9'h1E0

`endif

// file: i2cms_pkg.sv
/*
 * Types shared by the two-wire serial controller: the register access
 * request, the status layout and the master sequencer states.
 */
package i2cms_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } i2cms_sfr_req_t;

  typedef struct packed {
    logic general_call_flag;
    logic stop_flag;
    logic irq_flag;
    logic tx_flag;
    logic bus_busy_flag;
    logic arbitration_lost_flag;
    logic nack_seen_flag;
    logic slave_role_flag;
  } i2cms_status_t;

  typedef enum logic [4:0] {
    I2CMS_M_IDLE   = 5'b00001,
    I2CMS_M_START  = 5'b00010,
    I2CMS_M_RUN    = 5'b00100,
    I2CMS_M_RSTART = 5'b01000,
    I2CMS_M_STOP   = 5'b10000
  } i2cms_mst_t;

endpackage

// file: tb_i2c_master_slave_status_and_timing.sv
/* Self-checking bench for the serial controller core.
   Uses i2cms_bus_peer as the far side and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module tb_i2c_master_slave_status_and_timing;
  logic                      clk      = 1'b0;
  logic                      resetn   = 1'b0;
  i2cms_pkg::i2cms_sfr_req_t req      = '0;
  logic [7:0]                hp       = 8'h28;
  logic                      ack_on   = 1'b1;
  logic [7:0]                rdata, rx, st, v, e, ctl;
  logic [6:0]                oa, ab;
  logic                      irq, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl_n, m_sda_n, a;
  int                        mismatches = 0;
  int                        cmp_count  = 0;
  int                        k;
  logic [10:0] divs [8] = '{11'h010, 11'h018, 11'h01E, 11'h03C, 11'h078, 11'h0F0,
                            11'h1E0, 11'h3C0};
  logic [7:0]  rsts [6] = '{8'hD2, 8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hD3};
  logic [7:0]  rwa  [4] = '{8'hD2, 8'hDB, 8'hD9, 8'hD3};
  // Address cases: b0 ack, b1 ack enable, b2 gc enable, b4 gc address, b5 foreign
  logic [7:0]  cs   [5] = '{8'h03, 8'h00, 8'h17, 8'h12, 8'h26};
  wire scl = (scl_oe_n | scl_o) & m_scl_n;
  wire sda = (sda_oe_n | sda_o) & m_sda_n;

  always #5 clk = ~clk;

  i2cms_core i2cms_core_i (.clk(clk), .resetn(resetn), .sfr_req(req), .sfr_rdata(rdata),
    .irq(irq), .scl_in(scl), .scl_out(scl_o), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n(sda_oe_n));
  i2cms_bus_peer i2cms_bus_peer_i (.clk(clk), .scl(scl), .sda(sda), .hp(hp),
    .ack_on(ack_on), .scl_n(m_scl_n), .sda_n(m_sda_n), .rx(rx));

  function automatic logic [7:0] mst_exp(input logic ack);
    return {2'b00, 2'b11, 2'b00, ~ack, 1'b0};
  endfunction
  function automatic logic [7:0] slv_exp(input logic gc);
    return {gc, 3'b010, 4'b1001};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    req <= '{ad, 1'b1, 1'b0, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    req <= '{ad, 1'b0, 1'b1, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_irq();
    for (k = 0; k < 30000 && irq !== 1'b1; k++) @(posedge clk);
    if (irq !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask

  initial begin
    void'($urandom(32'h3170DADE));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    foreach (rsts[i]) begin
      rd(rsts[i], v);
      `CHK("reset value", 8'h00, v)
    end
    foreach (rwa[i]) begin
      v = $urandom;
      wr(rwa[i], v);
      rd(rwa[i], st);
      `CHK("reg access", (i < 2) ? v : 8'h00, st)
    end
    // Master write at every rate, random ack from the far side
    wr(8'hD2, 8'h00);
    for (int c = 0; c < 8; c++) begin
      v = {7'($urandom_range(1, 127)), 1'b0};
      wr(8'hDA, v);
      ack_on <= 1'($urandom);
      ctl = {c[2], 3'b110, 2'b01, c[1:0]};
      wr(8'hD8, ctl);
      wait_irq();
      `CHK("master byte", v, rx)
      rd(8'hD9, st);
      `CHK("master status", mst_exp(ack_on), st & 8'h37)
      rd(8'hD9, st);
      `CHK("irq cleared", 1'b0, st[5])
      wr(8'hD8, ctl ^ 8'h30);
      repeat (2 * divs[c] + 20) @(posedge clk);
      `CHK("bus idle", 2'b11, {scl, sda})
    end
    // Slave addressing table, filter lengths varied
    oa = 7'($urandom_range(2, 127));
    for (int c = 0; c < 5; c++) begin
      e = cs[c];
      wr(8'hD2, (c == 0) ? 8'h00 : (8'h80 | 8'($urandom_range(0, 11))));
      wr(8'hDB, {oa, e[2]});
      ctl = {5'b01000, e[1], 2'b00};
      wr(8'hD8, ctl);
      hp <= 8'($urandom_range(30, 60));
      ab = e[4] ? 7'h00 : (e[5] ? oa ^ 7'h01 : oa);
      i2cms_bus_peer_i.m_start();
      i2cms_bus_peer_i.m_byte({ab, 1'b0}, a);
      `CHK("address ack", ~e[0], a)
      if (e[0]) begin
        wait_irq();
        rd(8'hD9, st);
        `CHK("slave status", slv_exp(e[4]), st & 8'hB9)
        wr(8'hD8, ctl);
        v = $urandom;
        i2cms_bus_peer_i.m_byte(v, a);
        `CHK("data ack", 1'b0, a)
        wait_irq();
        rd(8'hDA, st);
        `CHK("slave data", v, st)
        rd(8'hD9, st);
        wr(8'hD8, ctl);
      end
      i2cms_bus_peer_i.m_stop();
      repeat (40) @(posedge clk);
      rd(8'hD9, st);
      `CHK("stop flags", {1'b1, e[0] | ~|e[5:4]}, st[6:5])
    end
    wr(8'hD8, 8'h00);
    #1 `CHK("disabled lines", 2'b11, {scl_oe_n, sda_oe_n})
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(8'hD2, v);
    `CHK("setup after reset", 8'h00, v)
    wrap_up();
  end
endmodule
`default_nettype wire
